// File: src/artc_defines.vh
// Purpose: Shared constants of the converter result transfer block.
// Assumes: Included by bare name from the top design file of the block only.
// Notes:   Byte addresses sit on aligned 32-bit words of the register bus.
`ifndef ARTC_DEFINES_VH
`define ARTC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ARTC_OFS_AIE      8'h00
`define ARTC_OFS_RESULT   8'h04
`define ARTC_OFS_XCTL     8'h08
`define ARTC_OFS_XCNT     8'h0C
`define ARTC_OFS_SADDR    8'h10
`define ARTC_OFS_FMT      8'h14
`define ARTC_OFS_IRQ_STAT 8'h18
`define ARTC_OFS_IRQ_MASK 8'h1C

// ----------------------------------------------------------------------
// Field positions of the transfer control register
// ----------------------------------------------------------------------
`define ARTC_XCTL_FETCH   0
`define ARTC_XCTL_B1      1
`define ARTC_XCTL_CT      2
`define ARTC_XCTL_TB      3

// ----------------------------------------------------------------------
// Interrupt status bit positions and flag count
// ----------------------------------------------------------------------
`define ARTC_IRQ_CONV     0
`define ARTC_IRQ_DONE     1
`define ARTC_IRQ_WIDTH    2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ARTC_RST_AIE      8'h00
`define ARTC_RST_XCTL     4'h0
`define ARTC_RST_XCNT     8'h00
`define ARTC_RST_SADDR    16'h0200
`define ARTC_RST_RESULT   16'h0000

// ----------------------------------------------------------------------
// Bus answers and address step
// ----------------------------------------------------------------------
`define ARTC_RESP_OKAY    2'b00
`define ARTC_RESP_SLVERR  2'b10
`define ARTC_ADDR_STEP    16'h0002

`endif

// File: src/artc_result_format.v
// Purpose: Places a ten-bit conversion result in the sixteen-bit word.
// Assumes: The raw result is straight binary, bit nine most significant.
// Notes:   Purely combinational; the caller registers the output.
`timescale 1ns/10ps
`default_nettype none

module artc_result_format (
    input  wire [9:0]  raw_result,
    input  wire        twos_format,
    output wire [15:0] formatted
);

    // ------------------------------------------------------------------
    // Justification and coding
    // ------------------------------------------------------------------
    // Straight binary sits in the low ten bits; two's complement flips the
    // top bit to move mid-scale to zero and sits in the high ten bits.
    assign formatted = twos_format ?
        {~raw_result[9], raw_result[8:0], 6'h00} :
        {6'h00, raw_result};

endmodule

`default_nettype wire

// File: src/artc_sticky_irq.v
// Purpose: Sticky event flags with a mask and one level interrupt.
// Assumes: Events are one-cycle pulses; clear is a write-one mask.
// Notes:   A new event in the clearing cycle keeps its flag set.
`timescale 1ns/10ps
`default_nettype none

module artc_sticky_irq #(
    parameter WIDTH = 2
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] event_set,
    input  wire [WIDTH-1:0] clear_ones,
    input  wire             mask_we,
    input  wire [WIDTH-1:0] mask_wdata,
    output reg  [WIDTH-1:0] status,
    output reg  [WIDTH-1:0] mask,
    output wire             irq
);

    // ------------------------------------------------------------------
    // Flags and mask
    // ------------------------------------------------------------------
    // Set has priority over clear so no event is lost.
    always @(posedge aclk) begin
        if (!aresetn) begin
            status <= {WIDTH{1'b0}};
            mask   <= {WIDTH{1'b0}};
        end else begin
            status <= (status & ~clear_ones) | event_set;
            if (mask_we) begin
                mask <= mask_wdata;
            end
        end
    end

    // High while any unmasked flag is set.
    assign irq = |(status & mask);

endmodule

`default_nettype wire

// File: src/artc_top.v
// Purpose: Register file and data transfer controller of the converter.
// Assumes: AXI4-Lite slave; results arrive as one-cycle pulses.
// Notes:   Results moved to memory over a valid/ready word write port.
`timescale 1ns/10ps
`default_nettype none
`include "artc_defines.vh"

module artc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        result_valid,
    input  wire [9:0]  result_data,
    output reg  [7:0]  analog_input_enable_bits,
    output wire        mem_wvalid,
    input  wire        mem_wready,
    output reg  [15:0] mem_waddr,
    output reg  [15:0] mem_wdata,
    output wire        irq
);

    localparam S_OFF   = 2'h0;
    localparam S_WAIT  = 2'h1;
    localparam S_WRITE = 2'h2;

    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg  [15:0] conversion_result_reg;
    reg         result_format_select;
    reg         two_block_select;
    reg         continuous_transfer;
    reg         block_one_filled;
    reg         fetch_control;
    reg  [7:0]  transfer_count;
    reg  [15:0] start_address_field;
    reg  [1:0]  dtc_state;
    reg  [7:0]  xfer_left;
    reg         second_block;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    reg         wr_hit;
    wire        wr_fire;
    wire        rd_fire;
    wire        sa_write;
    wire        block_end;
    wire        last_block;
    wire [15:0] formatted;
    wire [15:0] sa_merged;
    wire [1:0]  irq_status;
    wire [1:0]  irq_mask;
    wire [1:0]  irq_events;
    wire [1:0]  irq_clear;
    wire [3:0]  xctl_read;

    // Merges the low sixteen bits of a write under its byte strobes.
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? new_val[7:0]  : old_val[7:0];
            merge16[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    // ------------------------------------------------------------------
    // Register bus write side
    // ------------------------------------------------------------------
    // Address and data are held separately and used once both are here.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign sa_write      = wr_fire && (aw_addr == `ARTC_OFS_SADDR);
    assign sa_merged     = merge16(start_address_field, w_data, w_strb);

    // Catches address and data, then answers once the write is done.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ARTC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ARTC_RESP_OKAY : `ARTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Decodes which write addresses hold a writable register.
    always @* begin
        case (aw_addr)
            `ARTC_OFS_AIE, `ARTC_OFS_XCTL, `ARTC_OFS_XCNT,
            `ARTC_OFS_SADDR, `ARTC_OFS_FMT, `ARTC_OFS_IRQ_STAT,
            `ARTC_OFS_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Plain configuration registers; the enables drive the analog inputs.
    always @(posedge aclk) begin
        if (!aresetn) begin
            analog_input_enable_bits <= `ARTC_RST_AIE;
            result_format_select     <= 1'b0;
            two_block_select         <= 1'b0;
            continuous_transfer      <= 1'b0;
            fetch_control            <= 1'b0;
            transfer_count           <= `ARTC_RST_XCNT;
            start_address_field      <= `ARTC_RST_SADDR;
        end else if (wr_fire && w_strb[0]) begin
            case (aw_addr)
                `ARTC_OFS_AIE: begin
                    analog_input_enable_bits <= w_data[7:0];
                end
                `ARTC_OFS_XCTL: begin
                    two_block_select    <= w_data[`ARTC_XCTL_TB];
                    continuous_transfer <= w_data[`ARTC_XCTL_CT];
                    fetch_control       <= w_data[`ARTC_XCTL_FETCH];
                end
                `ARTC_OFS_XCNT: begin
                    transfer_count <= w_data[7:0];
                end
                `ARTC_OFS_FMT: begin
                    result_format_select <= w_data[0];
                end
                default: begin
                    transfer_count <= transfer_count;
                end
            endcase
        end
        if (aresetn && sa_write) begin
            // Bit zero is forced low so the address stays word aligned.
            start_address_field <= {sa_merged[15:1], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------
    artc_result_format u_format (
        .raw_result  (result_data),
        .twos_format (result_format_select),
        .formatted   (formatted)
    );

    // Every new result is placed in the readable result register.
    always @(posedge aclk) begin
        if (!aresetn) begin
            conversion_result_reg <= `ARTC_RST_RESULT;
        end else if (result_valid) begin
            conversion_result_reg <= formatted;
        end
    end

    // ------------------------------------------------------------------
    // Data transfer controller
    // ------------------------------------------------------------------
    assign mem_wvalid = (dtc_state == S_WRITE);
    assign block_end  = mem_wvalid && mem_wready && (xfer_left == 8'h01);
    // One-block mode ends on every block, two-block mode on the second.
    assign last_block = !two_block_select || second_block;

    // Moves each result that arrives in S_WAIT to memory and walks the blocks.
    always @(posedge aclk) begin
        if (!aresetn) begin
            dtc_state    <= S_OFF;
            xfer_left    <= 8'h00;
            second_block <= 1'b0;
            mem_waddr    <= 16'h0000;
            mem_wdata    <= 16'h0000;
        end else if (sa_write) begin
            // A start address write (re)starts at the written address, or stops when the count is zero.
            dtc_state    <= (transfer_count != 8'h00) ? S_WAIT : S_OFF;
            xfer_left    <= transfer_count;
            second_block <= 1'b0;
            mem_waddr    <= {sa_merged[15:1], 1'b0};
        end else begin
            case (dtc_state)
                S_OFF: begin
                    dtc_state <= S_OFF;
                end
                S_WAIT: begin
                    if (transfer_count == 8'h00) begin
                        dtc_state <= S_OFF;
                    end else if (result_valid) begin
                        mem_wdata <= formatted;
                        dtc_state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (mem_wready) begin
                        mem_waddr <= mem_waddr + `ARTC_ADDR_STEP;
                        xfer_left <= xfer_left - 8'h01;
                        dtc_state <= S_WAIT;
                        if (block_end && !last_block) begin
                            second_block <= 1'b1;
                            xfer_left    <= transfer_count;
                        end else if (block_end && continuous_transfer) begin
                            second_block <= 1'b0;
                            xfer_left    <= transfer_count;
                            mem_waddr    <= start_address_field;
                        end else if (block_end) begin
                            dtc_state <= S_OFF;
                        end
                    end
                end
                default: begin
                    dtc_state <= S_OFF;
                end
            endcase
        end
    end

    // Tells which block was filled last; hardware wins over software.
    always @(posedge aclk) begin
        if (!aresetn) begin
            block_one_filled <= 1'b0;
        end else if (block_end && two_block_select) begin
            block_one_filled <= !second_block;
        end else if (wr_fire && w_strb[0] && aw_addr == `ARTC_OFS_XCTL) begin
            block_one_filled <= w_data[`ARTC_XCTL_B1];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Flag per result when idle, per completed block while transferring.
    assign irq_events[`ARTC_IRQ_CONV] = block_end ||
        (result_valid && dtc_state == S_OFF);
    assign irq_events[`ARTC_IRQ_DONE] = block_end && last_block &&
        !continuous_transfer && !sa_write;
    assign irq_clear = (wr_fire && w_strb[0] &&
        aw_addr == `ARTC_OFS_IRQ_STAT) ? w_data[1:0] : 2'b00;

    artc_sticky_irq #(
        .WIDTH (`ARTC_IRQ_WIDTH)
    ) u_irq (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .event_set  (irq_events),
        .clear_ones (irq_clear),
        .mask_we    (wr_fire && w_strb[0] &&
                     aw_addr == `ARTC_OFS_IRQ_MASK),
        .mask_wdata (w_data[1:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // ------------------------------------------------------------------
    // Register bus read side
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign xctl_read     = {two_block_select, continuous_transfer,
                            block_one_filled, fetch_control};

    // Selects read data; unused bits read zero.
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `ARTC_OFS_AIE:      rd_mux[7:0]  = analog_input_enable_bits;
            `ARTC_OFS_RESULT:   rd_mux[15:0] = conversion_result_reg;
            `ARTC_OFS_XCTL:     rd_mux[7:0]  = {4'h0, xctl_read};
            `ARTC_OFS_XCNT:     rd_mux[7:0]  = transfer_count;
            `ARTC_OFS_SADDR:    rd_mux[15:0] = start_address_field;
            `ARTC_OFS_FMT:      rd_mux[0]    = result_format_select;
            `ARTC_OFS_IRQ_STAT: rd_mux[1:0]  = irq_status;
            `ARTC_OFS_IRQ_MASK: rd_mux[1:0]  = irq_mask;
            default:            rd_hit       = 1'b0;
        endcase
    end

    // Registers the read answer and holds it until taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ARTC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `ARTC_RESP_OKAY : `ARTC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: tb/artc_mem_model.sv
// Purpose: Memory that takes words from the transfer controller.
// Assumes: One word accepted per handshake.
// Notes:   Stall sets wait cycles before ready is raised.
`timescale 1ns/10ps
`default_nettype none

module artc_mem_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        mem_wvalid,
    input  wire logic [15:0] mem_waddr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic [3:0]  stall,
    output var  logic        mem_wready
);
    logic [15:0] words [0:255];
    int          n_writes;
    logic [3:0]  wait_cnt;

    // Waits the stall count, then takes one word for one cycle.
    always @(posedge aclk) begin
        if (!aresetn) begin
            mem_wready <= 1'b0;
            wait_cnt <= 4'h0;
            n_writes <= 0;
        end else if (mem_wvalid && !mem_wready) begin
            if (wait_cnt >= stall) begin
                mem_wready <= 1'b1;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            mem_wready <= 1'b0;
            if (mem_wvalid && mem_wready) begin
                words[mem_waddr[8:1]] <= mem_wdata;
                n_writes <= n_writes + 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/artc_top_sva.sv
// Purpose: Port-level checks of the result transfer block.
// Assumes: Bound to artc_top; sees only its ports.
// Notes:   Read address is remembered to judge read data.
`timescale 1ns/10ps
`default_nettype none

module artc_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        result_valid,
    input wire logic        mem_wvalid,
    input wire logic        mem_wready,
    input wire logic [15:0] mem_waddr,
    input wire logic [15:0] mem_wdata
);
    logic [7:0] rd_addr;

    // Holds the address of the read that is being answered.
    always @(posedge aclk) begin
        if (!aresetn)
            rd_addr <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mem_hold:
    assert property (mem_wvalid && !mem_wready |=> mem_wvalid
        && $stable(mem_waddr) && $stable(mem_wdata))
        else $error("memory write dropped or changed");
    a_mem_cause:
    assert property ($rose(mem_wvalid) |-> $past(result_valid))
        else $error("memory write without a result");
    a_mem_aligned:
    assert property (mem_wvalid |-> mem_waddr[0] == 1'b0)
        else $error("odd memory address");
    a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response not held");
    a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data not held");
    a_aw_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_ctl_reserved:
    assert property (s_axi_rvalid && rd_addr == 8'h08
        |-> s_axi_rdata[31:4] == 28'h0000000)
        else $error("reserved control bits set");
    a_sa_bit0:
    assert property (s_axi_rvalid && rd_addr == 8'h10
        |-> s_axi_rdata[0] == 1'b0 && s_axi_rdata[31:16] == 16'h0000)
        else $error("start address bit zero set");
    a_result_just:
    assert property (s_axi_rvalid && rd_addr == 8'h04
        |-> s_axi_rdata[31:16] == 16'h0000
        && (s_axi_rdata[15:10] == 6'h00 || s_axi_rdata[5:0] == 6'h00))
        else $error("result not justified");
endmodule

bind artc_top artc_top_sva i_artc_top_sva (.aclk, .aresetn,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .result_valid, .mem_wvalid,
    .mem_wready, .mem_waddr, .mem_wdata);
`default_nettype wire

// File: tb/artc_top_test.sv
// Purpose: Self-checking bench of the result transfer block.
// Assumes: Bus tasks are entered just after a rising edge.
// Notes:   Register cases in a table, transfers hand-written.
`timescale 1ns/10ps
`default_nettype none

module artc_top_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, result_valid;
    logic mem_wvalid, mem_wready, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, analog_input_enable_bits;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb, stall;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [9:0]  result_data;
    logic [15:0] mem_waddr, mem_wdata;
    int          failures, n_compared, i;
    logic [75:0] rows [0:7];

    artc_top i_artc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .result_valid,
        .result_data, .analog_input_enable_bits, .mem_wvalid, .mem_wready,
        .mem_waddr, .mem_wdata, .irq);
    artc_mem_model i_artc_mem_model (.aclk, .aresetn, .mem_wvalid,
        .mem_waddr, .mem_wdata, .stall, .mem_wready);

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One write: address and data offered together, response awaited.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_go, w_go, t_aw, t_w, b_go;
        int   n;
        aw_go = 1'b1;
        w_go = 1'b1;
        b_go = 1'b1;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; b_go && n < 50; n++) begin
            @(negedge aclk);
            t_aw = aw_go && s_axi_awready;
            t_w = w_go && s_axi_wready;
            b_go = !s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (t_aw) s_axi_awvalid <= 1'b0;
            if (t_w) s_axi_wvalid <= 1'b0;
            aw_go = aw_go && !t_aw;
            w_go = w_go && !t_w;
        end
        if (b_go) chk(32'hDEAD, 32'h0);
    endtask

    // One read: address held until taken, data taken with rvalid.
    task automatic axi_read(input logic [7:0] a);
        logic ar_go, t_ar, r_go;
        int   n;
        ar_go = 1'b1;
        r_go = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; r_go && n < 50; n++) begin
            @(negedge aclk);
            t_ar = ar_go && s_axi_arready;
            r_go = !s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (t_ar) s_axi_arvalid <= 1'b0;
            ar_go = ar_go && !t_ar;
        end
        if (r_go) chk(32'hDEAD, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        chk(got, e);
    endtask

    // Sends one result pulse and checks how many words memory holds.
    task automatic send(input logic [9:0] raw, input int n);
        int k;
        result_data <= raw;
        result_valid <= 1'b1;
        @(posedge aclk);
        result_valid <= 1'b0;
        for (k = 0; k < 60 && i_artc_mem_model.n_writes < n; k++)
            @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk(i_artc_mem_model.n_writes, n);
    endtask

    task automatic final_report;
        $display("%0d compared, %0d failures", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Free-running 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        $display("Error at %0t: run timed out", $time);
        final_report;
    end

    initial begin
        rows = '{{8'h00, 32'hA5, 32'hA5, 2'b00, 2'b00},
                 {8'h08, 32'hFF, 32'h0F, 2'b00, 2'b00},
                 {8'h0C, 32'h1FF, 32'hFF, 2'b00, 2'b00},
                 {8'h10, 32'hFFFF, 32'hFFFE, 2'b00, 2'b00},
                 {8'h14, 32'h1, 32'h1, 2'b00, 2'b00},
                 {8'h1C, 32'h3, 32'h3, 2'b00, 2'b00},
                 {8'h04, 32'hFFFF, 32'h0, 2'b10, 2'b00},
                 {8'h20, 32'h1234, 32'h0, 2'b10, 2'b10}};
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, result_valid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_wstrb, stall, result_data} = 18'h0;
        {failures, n_compared} = 64'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(8'h10, 32'h0200);
        rd_chk(8'h08, 32'h0);
        chk({mem_wvalid, irq, analog_input_enable_bits}, 32'h0);
        $display("reset test done");
        // Each row: write, check response, read back, check value.
        for (i = 0; i < 8; i++) begin
            axi_write(rows[i][75:68], rows[i][67:36]);
            chk(resp, rows[i][3:2]);
            rd_chk(rows[i][75:68], rows[i][35:4]);
            chk(resp, rows[i][1:0]);
        end
        chk(analog_input_enable_bits, 32'hA5);
        axi_write(8'h0C, 32'h0);
        axi_write(8'h08, 32'h0);
        $display("table test done");
        // One block of two binary results, memory stalling.
        stall <= 4'h3;
        axi_write(8'h14, 32'h0);
        axi_write(8'h18, 32'h3);
        axi_write(8'h0C, 32'h2);
        axi_write(8'h10, 32'h0100);
        send(10'h3FF, 1);
        rd_chk(8'h18, 32'h0);
        send(10'h155, 2);
        chk(i_artc_mem_model.words[8'h80], 32'h03FF);
        chk(i_artc_mem_model.words[8'h81], 32'h0155);
        rd_chk(8'h18, 32'h3);
        chk(irq, 32'h1);
        rd_chk(8'h04, 32'h0155);
        axi_write(8'h18, 32'h3);
        chk(irq, 32'h0);
        send(10'h2AA, 2);
        rd_chk(8'h18, 32'h1);
        chk(irq, 32'h1);
        axi_write(8'h1C, 32'h2);
        chk(irq, 32'h0);
        $display("single block test done");
        // Two blocks of one, continuous, two's complement.
        stall <= 4'h0;
        axi_write(8'h14, 32'h1);
        axi_write(8'h0C, 32'h1);
        axi_write(8'h08, 32'h0C);
        axi_write(8'h10, 32'h0180);
        send(10'h001, 3);
        chk(i_artc_mem_model.words[8'hC0], 32'h8040);
        rd_chk(8'h08, 32'h0E);
        send(10'h3FF, 4);
        chk(i_artc_mem_model.words[8'hC1], 32'h7FC0);
        rd_chk(8'h08, 32'h0C);
        send(10'h000, 5);
        chk(i_artc_mem_model.words[8'hC0], 32'h8000);
        rd_chk(8'h04, 32'h8000);
        axi_write(8'h0C, 32'h0);
        send(10'h0AA, 5);
        $display("two block test done");
        final_report;
    end
endmodule
`default_nettype wire
